/* File: logic/mcms_pkg.sv */
/*
 Shared constants and types for the motion command multitask scheduler:
 servo cycle and pre-calculation timing, register map, command and move codes.
 Assumes a 20 MHz clock and a 32-bit AXI4-Lite register bus.
*/
package mcms_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int unsigned SERVO_NS      = 120_000;
  localparam int unsigned SERVO_CYC     = SERVO_NS / CLK_NS;
  localparam int unsigned PRE_DUR_US    = 2000;
  localparam int unsigned PRE_VEL_US    = 4000;
  localparam int unsigned PRE_DUR_CYC   = PRE_DUR_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PRE_VEL_CYC   = PRE_VEL_US * (CLK_HZ / 1_000_000);
  localparam logic [11:0] SERVO_LAST    = 12'(SERVO_CYC - 1);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_HOST_CMD = 8'h08;
  localparam int unsigned CTRL_HALT_CLR = 0;
  localparam int unsigned CTRL_REF_CLR  = 1;
  localparam int unsigned STS_KIND_LSB  = 8;
  localparam int unsigned STS_ST_LSB    = 11;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  // ----------------------------------------------------------------
  // Status bit positions (also the wait-on-bit selector)
  // ----------------------------------------------------------------
  localparam int unsigned SB_TRAJ       = 0;
  localparam int unsigned SB_MT         = 1;
  localparam int unsigned SB_HALT       = 2;
  localparam int unsigned SB_PEND       = 3;
  localparam int unsigned SB_MOVE       = 4;
  localparam int unsigned SB_REFUSED    = 5;
  localparam int unsigned SB_HOST       = 6;

  // ----------------------------------------------------------------
  // Commands and moves
  // ----------------------------------------------------------------
  // OP_TIMEVEL covers all twelve time/velocity based moves
  typedef enum logic [4:0] {
    OP_NOP        = 5'h00,
    OP_MT_ON      = 5'h01,
    OP_MT_OFF     = 5'h02,
    OP_TIMEVEL    = 5'h03,
    OP_VEL_MODE   = 5'h04,
    OP_PROFILE    = 5'h05,
    OP_PROF_OVR   = 5'h06,
    OP_PROF_EXIT  = 5'h07,
    OP_STEP_DIR   = 5'h08,
    OP_INPUT_MODE = 5'h09,
    OP_HARD_STOP  = 5'h0A,
    OP_STOP       = 5'h0B,
    OP_HALT       = 5'h0C,
    OP_KEEP_DRV   = 5'h0D,
    OP_END        = 5'h0E,
    OP_WAIT_BIT   = 5'h0F,
    OP_PARAM      = 5'h10
  } mcms_op_t;

  typedef enum logic [2:0] {
    MV_NONE = 3'h0,
    MV_TV   = 3'h1,
    MV_VEL  = 3'h2,
    MV_PROF = 3'h3,
    MV_SD   = 3'h4,
    MV_INP  = 3'h5
  } mcms_mv_t;

  typedef struct packed {
    mcms_op_t   op;
    logic       dur_based;
    logic [2:0] bit_sel;
    logic       bit_lvl;
  } mcms_cmd_t;

endpackage

/* File: logic/mcms_top.sv */
/*
 Motion command scheduler for a servo controller with multi-tasking.
 Takes program commands and host immediate commands, paces them on the
 servo cycle, runs pre-calculation pauses, queues a time/velocity move
 behind a busy trajectory unit and enforces move override classes.
 Assumes the trajectory unit raises traj_busy within one servo cycle of
 traj_start and holds it while a move or input mode is active.
*/
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module mcms_top #(
  parameter int unsigned PRE_DUR_CYC = mcms_pkg::PRE_DUR_CYC,
  parameter int unsigned PRE_VEL_CYC = mcms_pkg::PRE_VEL_CYC
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Program buffer
  input  wire logic              prog_valid,
  input  wire mcms_pkg::mcms_cmd_t prog_cmd,
  output logic                   prog_ack,
  output logic                   prog_abort,
  output logic                   prog_end,
  // Trajectory unit
  input  wire logic              traj_busy,
  output logic                   traj_start,
  output mcms_pkg::mcms_mv_t     traj_kind,
  output logic                   traj_hard_stop,
  output logic                   traj_decel_stop,
  output logic                   traj_update,
  // Recovery and drivers
  output logic                   kill_recovery,
  output logic                   drv_enable,
  output logic                   servo_tick
);
  import mcms_pkg::*;

  // ----------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_RUN   = 5'h01,
    ST_CALC  = 5'h02,
    ST_QUEUE = 5'h04,
    ST_WBIT  = 5'h08,
    ST_ENDW  = 5'h10
  } mcms_st_t;

  function automatic logic [2:0] reg_dec(input logic [7:0] a);
    reg_dec = {a == ADDR_HOST_CMD, a == ADDR_STATUS, a == ADDR_CTRL};
  endfunction

  function automatic mcms_mv_t kind_of(input mcms_op_t o);
    case (o)
      OP_VEL_MODE:   kind_of = MV_VEL;
      OP_PROFILE:    kind_of = MV_PROF;
      OP_PROF_OVR:   kind_of = MV_PROF;
      OP_STEP_DIR:   kind_of = MV_SD;
      OP_INPUT_MODE: kind_of = MV_INP;
      default:       kind_of = MV_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [11:0] div_reg;
  logic        tick_reg;
  mcms_st_t    st_reg;
  mcms_st_t    st_next;
  mcms_mv_t    act_reg;
  mcms_mv_t    act_next;
  logic [16:0] cnt_reg;
  logic [16:0] cnt_next;
  logic        mt_reg;
  logic        keep_reg;
  logic        halt_reg;
  logic        ref_reg;
  logic        pdur_reg;
  logic [2:0]  wsel_reg;
  logic        wlvl_reg;
  logic        hpend_reg;
  mcms_cmd_t   hcmd_reg;
  logic        awh_reg;
  logic        wh_reg;
  logic [7:0]  awa_reg;
  logic [31:0] wd_reg;
  logic [3:0]  ws_reg;

  // ----------------------------------------------------------------
  // Command selection
  // ----------------------------------------------------------------
  wire       run      = st_reg == ST_RUN;
  wire       moving   = act_reg != MV_NONE;
  wire       mt_hold  = !mt_reg && moving;
  wire       ex_host  = tick_reg && hpend_reg;
  wire       ex_prog  = tick_reg && !hpend_reg && prog_valid && run && !mt_hold;
  wire       ex       = ex_host || ex_prog;
  mcms_cmd_t cur;
  assign cur = ex_host ? hcmd_reg : prog_cmd;
  wire       o_hsm    = cur.op == OP_HARD_STOP;
  wire       o_stp    = cur.op == OP_STOP;
  wire       o_hlt    = cur.op == OP_HALT;
  wire       o_brk    = o_hsm || o_stp || o_hlt;
  wire       o_vel    = cur.op == OP_VEL_MODE;
  wire       o_povr   = cur.op == OP_PROF_OVR;
  wire       o_pex    = cur.op == OP_PROF_EXIT;
  wire       o_tv     = cur.op == OP_TIMEVEL;
  wire       o_mv     = kind_of(cur.op) != MV_NONE;

  // ----------------------------------------------------------------
  // Override classes
  // ----------------------------------------------------------------
  wire ok_pex  = o_pex && (act_reg == MV_TV || act_reg == MV_PROF);
  wire ok_prof = cur.op == OP_PROFILE && act_reg == MV_PROF;
  wire ok_sd   = cur.op == OP_STEP_DIR && act_reg == MV_SD;
  // Velocity mode and profile override replace every class
  wire ovr_ok  = !moving || o_vel || o_povr || ok_prof || ok_sd;
  wire mv_go   = ex && o_mv && ovr_ok;
  wire mv_ref  = ex && o_mv && !ovr_ok;
  // A host time/velocity move is refused whenever the scheduler is not in ST_RUN
  wire tv_ref  = ex && o_tv && !run;
  wire tv_go   = ex && o_tv && run;
  wire cancel  = ex && (o_brk || o_vel || o_povr || o_pex);
  wire tv_pend = st_reg == ST_CALC || st_reg == ST_QUEUE;
  wire cdone   = st_reg == ST_CALC && cnt_reg == 17'h00000 && tick_reg && !cancel;
  wire q_free  = st_reg == ST_QUEUE && tick_reg && !traj_busy && !cancel;
  logic [7:0] stat;
  assign stat = {1'b0, hpend_reg, ref_reg, moving, tv_pend, halt_reg, mt_reg, traj_busy};
  wire wb_hit  = stat[wsel_reg] == wlvl_reg;
  wire end_w   = ex && cur.op == OP_END && mt_reg && moving;
  wire end_now = ex && cur.op == OP_END && !end_w;
  wire endw_ok = st_reg == ST_ENDW && !moving;
  wire start_n = mv_go || cdone;
  wire pex_go  = ex && ok_pex;
  wire upd_n   = ex && cur.op == OP_PARAM &&
                 ((mt_reg && act_reg == MV_PROF) || act_reg == MV_INP);

  // Load leaves one servo cycle of slack so the start tick stays in limit
  wire        use_dur = (st_reg == ST_QUEUE) ? pdur_reg : cur.dur_based;
  wire [16:0] pre_ld  = use_dur ? 17'(PRE_DUR_CYC - SERVO_CYC)
                                : 17'(PRE_VEL_CYC - SERVO_CYC);

  // ----------------------------------------------------------------
  // Scheduler state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next  = st_reg;
    cnt_next = (cnt_reg != 17'h00000) ? cnt_reg - 17'h00001 : cnt_reg;
    case (st_reg)
      ST_RUN:
      begin
        if (tv_go && traj_busy)
          st_next = ST_QUEUE;
        else if (tv_go)
        begin
          st_next  = ST_CALC;
          cnt_next = pre_ld;
        end
        else if (ex && cur.op == OP_WAIT_BIT)
          st_next = ST_WBIT;
        else if (end_w)
          st_next = ST_ENDW;
      end
      ST_CALC:
        if (cancel || cdone)
          st_next = ST_RUN;
      ST_QUEUE:
        if (cancel)
          st_next = ST_RUN;
        else if (q_free)
        begin
          st_next  = ST_CALC;
          cnt_next = pre_ld;
        end
      ST_WBIT:
        if ((tick_reg && wb_hit) || (ex && (o_stp || o_hlt)))
          st_next = ST_RUN;
      ST_ENDW:
        if (endw_ok || (ex && (o_stp || o_hlt)))
          st_next = ST_RUN;
      default:
        st_next = ST_RUN;
    endcase
  end

  // Move class tracking; an idle trajectory at a tick ends the move
  always_comb
  begin
    act_next = act_reg;
    if (ex && (o_brk || pex_go))
      act_next = MV_NONE;
    else if (mv_go)
      act_next = kind_of(cur.op);
    else if (cdone)
      act_next = MV_TV;
    else if (tick_reg && !traj_busy)
      act_next = MV_NONE;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_reg  <= 12'h000;
      tick_reg <= 1'b0;
      st_reg   <= ST_RUN;
      act_reg  <= MV_NONE;
      cnt_reg  <= 17'h00000;
    end
    else
    begin
      div_reg  <= (div_reg == SERVO_LAST) ? 12'h000 : div_reg + 12'h001;
      tick_reg <= div_reg == SERVO_LAST;
      st_reg   <= st_next;
      act_reg  <= act_next;
      cnt_reg  <= cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Mode flags
  // ----------------------------------------------------------------
  wire wr_do  = awh_reg && wh_reg && !s_axi_bvalid;
  wire [2:0] wsel = reg_dec(awa_reg);
  wire ctrl_w = wr_do && wsel[0] && ws_reg[0];
  wire hcmd_w = wr_do && wsel[2] && (&ws_reg[1:0]) && !hpend_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mt_reg    <= 1'b0;
      keep_reg  <= 1'b0;
      halt_reg  <= 1'b0;
      ref_reg   <= 1'b0;
      pdur_reg  <= 1'b0;
      wsel_reg  <= 3'h0;
      wlvl_reg  <= 1'b0;
      hpend_reg <= 1'b0;
      hcmd_reg  <= '0;
    end
    else
    begin
      mt_reg   <= (ex && cur.op == OP_MT_ON) || (mt_reg && !(ex && cur.op == OP_MT_OFF));
      keep_reg <= keep_reg || (ex && cur.op == OP_KEEP_DRV);
      // Hardware set beats a software clear in the same cycle
      halt_reg <= (ex && o_hlt) || (halt_reg && !(ctrl_w && wd_reg[CTRL_HALT_CLR]));
      ref_reg  <= mv_ref || tv_ref || (ref_reg && !(ctrl_w && wd_reg[CTRL_REF_CLR]));
      pdur_reg <= tv_go ? cur.dur_based : pdur_reg;
      if (ex && cur.op == OP_WAIT_BIT)
      begin
        wsel_reg <= cur.bit_sel;
        wlvl_reg <= cur.bit_lvl;
      end
      hpend_reg <= hcmd_w || (hpend_reg && !ex_host);
      hcmd_reg  <= hcmd_w ? mcms_cmd_t'(wd_reg[$bits(mcms_cmd_t)-1:0]) : hcmd_reg;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs to program buffer, trajectory unit, recovery and drivers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prog_ack        <= 1'b0;
      prog_abort      <= 1'b0;
      prog_end        <= 1'b0;
      traj_start      <= 1'b0;
      traj_kind       <= MV_NONE;
      traj_hard_stop  <= 1'b0;
      traj_decel_stop <= 1'b0;
      traj_update     <= 1'b0;
      kill_recovery   <= 1'b0;
      drv_enable      <= 1'b0;
      servo_tick      <= 1'b0;
    end
    else
    begin
      prog_ack        <= ex_prog;
      prog_abort      <= ex && (o_stp || o_hlt);
      prog_end        <= end_now || endw_ok;
      traj_start      <= start_n;
      traj_kind       <= cdone ? MV_TV : kind_of(cur.op);
      traj_hard_stop  <= ex && (o_hsm || o_hlt);
      traj_decel_stop <= ex && o_stp || pex_go;
      traj_update     <= upd_n;
      kill_recovery   <= ex && o_hlt;
      // Multi-tasking off always drops drivers during recovery
      drv_enable      <= !halt_reg || (mt_reg && keep_reg);
      servo_tick      <= tick_reg;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire awh_n   = (awh_reg && !wr_do) || aw_take;
  wire wh_n    = (wh_reg && !wr_do) || w_take;
  wire bv_n    = wr_do || (s_axi_bvalid && !s_axi_bready);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire rv_n    = ar_take || (s_axi_rvalid && !s_axi_rready);
  wire [2:0] rsel = reg_dec(s_axi_araddr);
  wire [1:0] wresp = (wsel == 3'h0) ? RESP_DECERR :
                     (wsel[2] && !hcmd_w) ? RESP_SLVERR : RESP_OKAY;

  logic [31:0] rd_val;
  assign rd_val =
    rsel[1] ? {16'h0000, st_reg, act_reg, stat} :
    rsel[2] ? {22'h000000, hcmd_reg} : 32'h00000000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awh_reg       <= 1'b0;
      wh_reg        <= 1'b0;
      awa_reg       <= 8'h00;
      wd_reg        <= 32'h00000000;
      ws_reg        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      awh_reg       <= awh_n;
      wh_reg        <= wh_n;
      awa_reg       <= aw_take ? s_axi_awaddr : awa_reg;
      if (w_take)
      begin
        wd_reg <= s_axi_wdata;
        ws_reg <= s_axi_wstrb;
      end
      s_axi_awready <= !awh_n && !bv_n;
      s_axi_wready  <= !wh_n && !bv_n;
      s_axi_bvalid  <= bv_n;
      s_axi_bresp   <= wr_do ? wresp : s_axi_bresp;
      s_axi_arready <= !rv_n;
      s_axi_rvalid  <= rv_n;
      if (ar_take)
      begin
        s_axi_rdata <= rd_val;
        s_axi_rresp <= (rsel == 3'h0) ? RESP_DECERR : RESP_OKAY;
      end
    end
  end

endmodule

/* File: test/mcms_far_model.sv */
/*
 Far side model: program buffer holding one command, and a trajectory unit.
 Assumes the bench pushes a command only while prog_valid is low.
*/
`timescale 1ns/10ps
module mcms_far_model
  import mcms_pkg::*;
#(
  parameter int unsigned MOVE_CYC = 5000
) (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Bench side
  input wire logic                push,
  input wire mcms_pkg::mcms_cmd_t push_cmd,
  // Program buffer
  output logic                    prog_valid,
  output mcms_pkg::mcms_cmd_t     prog_cmd,
  input wire logic                prog_ack,
  // Trajectory unit
  input wire logic                traj_start,
  input wire logic                traj_hard_stop,
  input wire logic                traj_decel_stop,
  output logic                    traj_busy
);
  int unsigned left_q;
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      prog_valid <= 1'b0;
      prog_cmd   <= '0;
      traj_busy  <= 1'b0;
      left_q     <= 0;
    end
    else
    begin
      // Released command word is scrambled, not left looking valid
      if (push)
      begin
        prog_valid <= 1'b1;
        prog_cmd   <= push_cmd;
      end
      else if (prog_ack)
      begin
        prog_valid <= 1'b0;
        prog_cmd   <= ~prog_cmd;
      end
      // Deceleration shortened to one cycle; keeps runs brief
      if (traj_hard_stop || traj_decel_stop)
        left_q <= 0;
      else if (traj_start)
        left_q <= MOVE_CYC;
      else if (left_q != 0)
        left_q <= left_q - 1;
      traj_busy <= !(traj_hard_stop || traj_decel_stop) && (traj_start || left_q > 1);
    end
endmodule

/* File: test/mcms_properties.sv */
/*
 Port checker for the motion command scheduler.
 Assumes the mcms_pkg package and the mcms_top port names.
*/
`timescale 1ns/10ps
module mcms_properties
  import mcms_pkg::*;
(
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // Register read channel
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic [31:0]        s_axi_rdata,
  // Program buffer
  input wire logic               prog_valid,
  input wire logic               prog_ack,
  input wire logic               prog_abort,
  input wire logic               prog_end,
  // Trajectory and recovery
  input wire logic               traj_busy,
  input wire logic               traj_start,
  input wire mcms_pkg::mcms_mv_t traj_kind,
  input wire logic               traj_hard_stop,
  input wire logic               traj_decel_stop,
  input wire logic               kill_recovery,
  input wire logic               servo_tick
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------------------------------
  // Tick spacing counter
  // ----------------------------------------------------------------
  logic [11:0] gap_q;
  logic        seen_q;
  always_ff @(posedge aclk)
    if (!aresetn)
    begin
      gap_q  <= 12'h000;
      seen_q <= 1'b0;
    end
    else
    begin
      gap_q  <= servo_tick ? 12'h001 : gap_q + 12'h001;
      seen_q <= seen_q | servo_tick;
    end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_tick_period: assert property (servo_tick && seen_q |-> gap_q == 12'(SERVO_CYC))
    else $error("servo tick spacing wrong");
  a_ack_on_tick: assert property (prog_ack |-> servo_tick && $past(prog_valid))
    else $error("command taken off tick");
  a_start_on_tick: assert property (traj_start |-> servo_tick && traj_kind != MV_NONE)
    else $error("move start off tick or kindless");
  a_start_single: assert property (traj_start |=> !traj_start [*8])
    else $error("move start repeated");
  a_abort_cause: assert property (prog_abort |-> traj_hard_stop || traj_decel_stop)
    else $error("abort without stopping motion");
  a_halt_full: assert property (kill_recovery |-> traj_hard_stop && prog_abort)
    else $error("halt incomplete");
  a_end_idle: assert property (prog_end |-> !$past(traj_busy))
    else $error("end while move active");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

bind mcms_top mcms_properties u_props (
  .aclk, .aresetn, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .prog_valid, .prog_ack, .prog_abort, .prog_end, .traj_busy, .traj_start,
  .traj_kind, .traj_hard_stop, .traj_decel_stop, .kill_recovery, .servo_tick
);

/* File: test/test_motion_command_multitask_scheduler.sv */
/*
 Bench for the scheduler: AXI4-Lite tasks and command sequences.
 Assumes the far model and the bound port checker.
*/
`timescale 1ns/10ps
module test_motion_command_multitask_scheduler;
  import mcms_pkg::*;
  logic aclk = 0, aresetn = 0, push = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic prog_valid, prog_ack, prog_abort, prog_end, traj_busy, traj_start;
  logic traj_hard_stop, traj_decel_stop, traj_update, kill_recovery, drv_enable, servo_tick;
  mcms_cmd_t prog_cmd, push_cmd = '0;
  mcms_mv_t  traj_kind;
  int failures = 0, n_compared = 0, n;
  wire [7:0] ev = {~prog_valid, ~traj_busy, prog_end, kill_recovery,
                   traj_decel_stop, traj_hard_stop, traj_start, prog_ack};

  always #25 aclk = ~aclk;

  mcms_top #(.PRE_DUR_CYC(4800), .PRE_VEL_CYC(7200)) dut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .prog_valid, .prog_cmd, .prog_ack,
    .prog_abort, .prog_end, .traj_busy, .traj_start, .traj_kind, .traj_hard_stop,
    .traj_decel_stop, .traj_update, .kill_recovery, .drv_enable, .servo_tick);
  mcms_far_model #(.MOVE_CYC(5000)) u_far (
    .aclk, .aresetn, .push, .push_cmd, .prog_valid, .prog_cmd, .prog_ack,
    .traj_start, .traj_hard_stop, .traj_decel_stop, .traj_busy);

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task hang;
    failures++;
    tally_and_finish();
  endtask
  task wait_ev(input int b, input int lim);
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end while (ev[b] !== 1'b1 && n < lim);
    if (n >= lim) hang();
  endtask
  // Waits for a free buffer slot, then hands over one command
  task cmd(input mcms_op_t op, input logic [4:0] a);
    wait_ev(7, 30000);
    push     <= 1'b1;
    push_cmd <= {op, a};
    @(posedge aclk);
    push     <= 1'b0;
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    for (i = 0; i < 40 && s_axi_bvalid !== 1'b1; i++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    if (i == 40) hang();
    check(32'(s_axi_bresp), 32'(er));
  endtask
  // Ready is raised only once data shows, so the slave must hold it
  task axi_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ed,
              input logic [1:0] er);
    int i;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    for (i = 0; i < 40 && !(s_axi_rvalid === 1'b1 && s_axi_rready); i++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end
    if (i == 40) hang();
    s_axi_rready <= 1'b0;
    check(s_axi_rdata & m, ed);
    check(32'(s_axi_rresp), 32'(er));
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    check(32'(drv_enable), 32'h1);
    axi_rd(ADDR_STATUS, 32'hFFFF, 32'h0800, RESP_OKAY);
    axi_rd(8'h0C, 32'hFFFFFFFF, 32'h0, RESP_DECERR);
    axi_wr(8'h0C, 32'h0, RESP_DECERR);
    $display("reset test done");
    cmd(OP_MT_ON, 5'h00);
    wait_ev(0, 3000);
    axi_rd(ADDR_STATUS, 32'h2, 32'h2, RESP_OKAY);
    cmd(OP_TIMEVEL, 5'h10);
    wait_ev(1, 12000);
    check(32'(traj_kind), 32'(MV_TV));
    check(32'(n <= 7204), 32'h1);
    cmd(OP_TIMEVEL, 5'h00);
    repeat (2500) @(posedge aclk);
    axi_rd(ADDR_STATUS, 32'h2008, 32'h2008, RESP_OKAY);
    wait_ev(1, 20000);
    check(32'(traj_kind), 32'(MV_TV));
    $display("queue test done");
    cmd(OP_VEL_MODE, 5'h00);
    wait_ev(1, 3000);
    check(32'(traj_kind), 32'(MV_VEL));
    cmd(OP_PROFILE, 5'h00);
    wait_ev(0, 3000);
    check(32'(traj_start), 32'h0);
    axi_rd(ADDR_STATUS, 32'h20, 32'h20, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h2, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h20, 32'h0, RESP_OKAY);
    cmd(OP_STOP, 5'h00);
    wait_ev(3, 3000);
    check(32'(prog_abort), 32'h1);
    cmd(OP_VEL_MODE, 5'h00);
    wait_ev(1, 3000);
    cmd(OP_HARD_STOP, 5'h00);
    wait_ev(2, 3000);
    check(32'(prog_abort), 32'h0);
    $display("override test done");
    cmd(OP_VEL_MODE, 5'h00);
    wait_ev(1, 3000);
    cmd(OP_END, 5'h00);
    wait_ev(5, 12000);
    check(32'(n > 4000), 32'h1);
    cmd(OP_VEL_MODE, 5'h00);
    wait_ev(1, 3000);
    cmd(OP_WAIT_BIT, {1'b0, 3'(SB_TRAJ), 1'b0});
    cmd(OP_PARAM, 5'h00);
    wait_ev(0, 12000);
    check(32'(traj_busy), 32'h0);
    cmd(OP_INPUT_MODE, 5'h00);
    wait_ev(1, 3000);
    check(32'(traj_kind), 32'(MV_INP));
    cmd(OP_PARAM, 5'h00);
    wait_ev(0, 3000);
    check(32'(traj_update), 32'h1);
    $display("program flow test done");
    cmd(OP_HALT, 5'h00);
    wait_ev(4, 3000);
    repeat (3) @(posedge aclk);
    check(32'(drv_enable), 32'h0);
    axi_rd(ADDR_STATUS, 32'h4, 32'h4, RESP_OKAY);
    axi_wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    @(posedge aclk);
    check(32'(drv_enable), 32'h1);
    cmd(OP_KEEP_DRV, 5'h00);
    cmd(OP_HALT, 5'h00);
    wait_ev(4, 6000);
    repeat (3) @(posedge aclk);
    check(32'(drv_enable), 32'h1);
    $display("halt test done");
    cmd(OP_MT_OFF, 5'h00);
    cmd(OP_STEP_DIR, 5'h00);
    wait_ev(1, 6000);
    check(32'(drv_enable), 32'h0);
    cmd(OP_PROF_EXIT, 5'h00);
    wait_ev(0, 12000);
    check(32'(n > 4000), 32'h1);
    axi_wr(ADDR_HOST_CMD, 32'h20, RESP_OKAY);
    axi_rd(ADDR_HOST_CMD, 32'h3FF, 32'h20, RESP_OKAY);
    repeat (2500) @(posedge aclk);
    axi_rd(ADDR_STATUS, 32'h42, 32'h2, RESP_OKAY);
    $display("mode test done");
    tally_and_finish();
  end
endmodule
